// ### core/kil_top.sv
// Keypad interrupt latch: five key pins, Wishbone slave, interrupt request out.
// Assumes pins are asynchronous; vector fetch arrives as a one-cycle pulse on clk_i.
// Notes on behaviour
// RULE1 - Five key pins, each with its own enable, one shared mask.
// RULE2 - An enabled pin also turns on its pull-up output.
// RULE3 - Latch a request when an enabled pin falls after all were high.
// RULE4 - Edge-only mode: no new latch while another enabled pin is low.
// RULE5 - Edge-and-level mode: request held while any enabled pin is low.
// RULE6 - Level mode clears only after acknowledge and all pins high, any order.
// RULE7 - Acknowledge write clears request; later falling edge latches anew.
// RULE8 - Unmasked request goes to the CPU; vector fetch acknowledges.
// RULE9 - Edge-only mode: acknowledge clears at once whatever the pins show.
// RULE10 - Reset clears request and sense select even with a pin low.
// RULE11 - Pending flag shows the request regardless of mask.
// RULE12 - Enabled pin is forced input; pin readable only when direction is input.
// RULE13 - Software masks, enables, acknowledges, then unmasks.
// RULE14 - Software may drive pins high as outputs before enabling them.
// RULE15 - Block runs in wait and stop; unmasked request wakes the CPU.
// RULE16 - Sense select 1 means edge and level, 0 means edge only.
// RULE17 - Acknowledge bit is write only and reads zero.
// RULE18 - Mask blocks the CPU request but latching goes on.
// RULE19 - Each pin passes two flip-flops before edge detection.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module kil_top
  import kil_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [31:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [KIL_PINS-1:0] key_interrupt_pins_i,
  input  wire logic [KIL_PINS-1:0] pin_dir_out_i,
  input  wire logic [KIL_PINS-1:0] pin_port_data_i,
  output logic      [KIL_PINS-1:0] pin_pullup_en_o,
  output logic      [KIL_PINS-1:0] pin_drive_o,
  output logic      [KIL_PINS-1:0] pin_drive_oe_o,
  output logic      [KIL_PINS-1:0] pin_read_valid_o,
  input  wire logic                vector_fetch_i,
  output logic                     cpu_irq_o,
  output logic                     wake_o
);
  // ==========================================
  // State
  // ==========================================
  logic [KIL_PINS-1:0] pin_interrupt_enables_reg;
  logic                request_mask_reg;
  logic                trigger_sense_select_reg;
  logic                request_pending_flag_reg;
  logic                ack_seen_reg;
  logic                all_high_prev_reg;
  logic [KIL_PINS-1:0] pin_sync;
  logic                all_high;
  logic                any_low;
  logic                fall_event;
  logic                bus_req;
  logic                wr_status;
  logic                request_acknowledge;
  logic                ack_any;
  logic                sel_low;

  // ==========================================
  // Pin synchronisation and event detection
  // ==========================================
  kil_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (key_interrupt_pins_i),
    .sync_o  (pin_sync)
  ); // RULE19

  assign all_high = &(pin_sync | ~pin_interrupt_enables_reg); // RULE1
  assign any_low  = ~all_high;
  assign fall_event = all_high_prev_reg && any_low; // RULE3 RULE4

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      all_high_prev_reg <= 1'b1;
    end else begin
      all_high_prev_reg <= all_high;
    end
  end

  // ==========================================
  // Wishbone slave
  // ==========================================
  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign sel_low   = wb_sel_i[0];
  assign wr_status = bus_req && wb_we_i && sel_low && (wb_adr_i[9:0] == KIL_ADDR_STATUS)
                     && (wb_adr_i[31:10] == 22'h000000);
  assign request_acknowledge = wr_status && wb_dat_i[KIL_BIT_ACK]; // RULE7
  assign ack_any = request_acknowledge || vector_fetch_i; // RULE8

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      request_mask_reg         <= KIL_RST_MASK;
      trigger_sense_select_reg <= KIL_RST_SENSE; // RULE10
    end else if (wr_status) begin
      request_mask_reg         <= wb_dat_i[KIL_BIT_MASK];
      trigger_sense_select_reg <= wb_dat_i[KIL_BIT_SENSE]; // RULE16
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_interrupt_enables_reg <= KIL_RST_ENABLE;
    end else if (bus_req && wb_we_i && sel_low && wb_adr_i == {22'h000000, KIL_ADDR_ENABLE}) begin
      pin_interrupt_enables_reg <= wb_dat_i[KIL_PINS-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= KIL_UNMAPPED;
    end else if (bus_req && !wb_we_i) begin
      if (wb_adr_i == {22'h000000, KIL_ADDR_STATUS}) begin
        wb_dat_o <= {28'h0000000, request_pending_flag_reg, 1'b0, request_mask_reg,
                     trigger_sense_select_reg}; // RULE11 RULE17
      end else if (wb_adr_i == {22'h000000, KIL_ADDR_ENABLE}) begin
        wb_dat_o <= {27'h0000000, pin_interrupt_enables_reg};
      end else begin
        wb_dat_o <= KIL_UNMAPPED;
      end
    end
  end

  // ==========================================
  // Request latch
  // ==========================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_seen_reg <= 1'b0;
    end else if (fall_event || !request_pending_flag_reg || all_high) begin
      ack_seen_reg <= 1'b0;
    end else if (ack_any) begin
      ack_seen_reg <= 1'b1; // RULE6
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      request_pending_flag_reg <= 1'b0; // RULE10
    end else if (fall_event) begin
      request_pending_flag_reg <= 1'b1; // RULE3 RULE7
    end else if (trigger_sense_select_reg) begin
      if ((ack_any || ack_seen_reg) && all_high) begin
        request_pending_flag_reg <= 1'b0; // RULE6
      end else if (any_low && request_pending_flag_reg) begin
        request_pending_flag_reg <= 1'b1; // RULE5
      end
    end else if (ack_any) begin
      request_pending_flag_reg <= 1'b0; // RULE9
    end
  end

  // ==========================================
  // Outputs
  // ==========================================
  assign cpu_irq_o = request_pending_flag_reg && !request_mask_reg; // RULE8 RULE18
  assign wake_o    = cpu_irq_o; // RULE15
  assign pin_pullup_en_o = pin_interrupt_enables_reg; // RULE2
  assign pin_drive_oe_o  = pin_dir_out_i & ~pin_interrupt_enables_reg; // RULE12
  assign pin_drive_o     = pin_port_data_i & pin_drive_oe_o;
  assign pin_read_valid_o = ~pin_dir_out_i; // RULE12
endmodule : kil_top

// ### core/kil_pkg.sv
// Package for the keypad interrupt latch: register map, field layout, reset values.
// Assumes a 32-bit Wishbone register bus with word-aligned registers.
package kil_pkg;
  localparam int          KIL_PINS        = 5;
  localparam logic [7:0]  KIL_IDX_STATUS  = 8'h1a;
  localparam logic [7:0]  KIL_IDX_ENABLE  = 8'h1b;
  localparam logic [9:0]  KIL_ADDR_STATUS = {KIL_IDX_STATUS, 2'b00};
  localparam logic [9:0]  KIL_ADDR_ENABLE = {KIL_IDX_ENABLE, 2'b00};
  localparam int          KIL_BIT_FLAG    = 3;
  localparam int          KIL_BIT_ACK     = 2;
  localparam int          KIL_BIT_MASK    = 1;
  localparam int          KIL_BIT_SENSE   = 0;
  localparam logic        KIL_RST_MASK    = 1'b0;
  localparam logic        KIL_RST_SENSE   = 1'b0;
  localparam logic [4:0]  KIL_RST_ENABLE  = 5'h00;
  localparam logic [31:0] KIL_UNMAPPED    = 32'h00000000;
endpackage : kil_pkg

// ### core/kil_sync.sv
// Two-flop synchroniser, one per key pin.
// Assumes pins are asynchronous to clk_i.
`timescale 1ns/1ps
module kil_sync
  import kil_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [KIL_PINS-1:0] async_i,
  output logic      [KIL_PINS-1:0] sync_o
);
  logic [KIL_PINS-1:0] meta_reg;
  genvar g;
  generate
    for (g = 0; g < KIL_PINS; g++) begin : g_pin
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_reg[g] <= 1'b1;
          sync_o[g]   <= 1'b1;
        end else begin
          meta_reg[g] <= async_i[g];
          sync_o[g]   <= meta_reg[g];
        end
      end
    end
  endgenerate
endmodule : kil_sync

// ### dv/kil_top_asserts.sv
// Port checker for kil_top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module kil_top_asserts
  import kil_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [4:0]  pin_dir_out_i,
  input wire logic [4:0]  pin_port_data_i,
  input wire logic [4:0]  pin_pullup_en_o,
  input wire logic [4:0]  pin_drive_o,
  input wire logic [4:0]  pin_drive_oe_o,
  input wire logic [4:0]  pin_read_valid_o,
  input wire logic        cpu_irq_o,
  input wire logic        wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ====
  // Bus handshake
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_en_wr;
    s_req ##0 wb_we_i && wb_adr_i == {22'h0, KIL_ADDR_ENABLE};
  endsequence
  ack_once_a: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
  ack_idle_a: assert property (!wb_cyc_i ##1 !wb_cyc_i |-> !wb_ack_o) else $error("ack without request");
  pullup_wr_a: assert property (s_en_wr |=> pin_pullup_en_o == $past(wb_dat_i[4:0]))
    else $error("pullups differ from enable write");
  // ====
  // Pins and request
  oe_excl_a: assert property (pin_drive_oe_o == (pin_dir_out_i & ~pin_pullup_en_o))
    else $error("enabled pin driven");
  drive_val_a: assert property (pin_drive_o == (pin_port_data_i & pin_drive_oe_o)) else $error("drive");
  read_ok_a: assert property (pin_read_valid_o == ~pin_dir_out_i) else $error("read valid");
  wake_irq_a: assert property (wake_o == cpu_irq_o) else $error("wake differs from irq");
  reset_clr_a: assert property (disable iff (1'b0) rst_i |=> !cpu_irq_o && pin_pullup_en_o == 5'h00)
    else $error("reset left state");
endmodule : kil_top_asserts
bind kil_top kil_top_asserts u_chk (.*);

// ### dv/kil_keys.sv
// Key switches to ground on the key pins.
// Assumes the design pull-ups and port drive are the only sources of a steady high level.
`timescale 1ns/1ps
module kil_keys
(
  input  wire logic       clk_i,
  input  wire logic [4:0] press_i,
  input  wire logic [4:0] pullup_i,
  input  wire logic [4:0] drive_i,
  output logic      [4:0] pins_o
);
  logic [4:0] float_reg = 5'h00;
  // Released pin without pull-up or port drive floats
  always @(posedge clk_i) float_reg <= ~float_reg;
  assign pins_o = ~press_i & (pullup_i | drive_i | float_reg);
endmodule : kil_keys

// ### dv/keypad_interrupt_latch_bench.sv
// Bench for kil_top: register access and key press sequences.
// Assumes kil_keys models the switches.
`timescale 1ns/1ps
module keypad_interrupt_latch_bench;
  import kil_pkg::*;
  logic       clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic       vector_fetch_i = 1'b0, wb_ack_o, cpu_irq_o, wake_o;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'h1;
  logic [4:0] key_interrupt_pins_i, pin_dir_out_i = 5'h03, pin_port_data_i = 5'h15, press = 5'h00;
  logic [4:0] pin_pullup_en_o, pin_drive_o, pin_drive_oe_o, pin_read_valid_o;
  logic [9:0] st = KIL_ADDR_STATUS, en = KIL_ADDR_ENABLE;
  int         checks = 0, miscompares = 0;
  always #2.5 clk_i = ~clk_i;
  kil_top u_dut (.*);
  kil_keys u_keys (.clk_i, .press_i(press), .pullup_i(pin_pullup_en_o), .drive_i(pin_drive_o),
                   .pins_o(key_interrupt_pins_i));
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [9:0] what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch reg %h expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic [9:0] a, input logic we, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    {wb_adr_i, wb_dat_i} <= {22'h0, a, 24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      $display("mismatch bus ack expected 1 seen %b", wb_ack_o);
    end
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk(a, exp, q);
  endtask : rd
  task automatic keys(input logic [4:0] v, input logic f);
    press <= v;
    vector_fetch_i <= f;
    @(posedge clk_i);
    vector_fetch_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : keys
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(st, 8'h00);
    rd(10'h3fc, 8'h00);
    wr(st, 8'h02);
    wr(en, 8'h1f);
    wr(st, 8'h06);
    rd(en, 8'h1f);
    keys(5'h01, 1'b0);
    rd(st, 8'h0a);
    chk(10'h0, 8'h00, {7'h0, cpu_irq_o});
    wr(st, 8'h04);
    rd(st, 8'h00);
    keys(5'h03, 1'b0);
    rd(st, 8'h00);
    keys(5'h00, 1'b0);
    keys(5'h04, 1'b0);
    chk(10'h0, 8'h01, {7'h0, cpu_irq_o});
    keys(5'h04, 1'b1);
    rd(st, 8'h00);
    keys(5'h00, 1'b0);
    wr(st, 8'h01);
    keys(5'h08, 1'b1);
    keys(5'h08, 1'b1);
    rd(st, 8'h09);
    keys(5'h00, 1'b0);
    rd(st, 8'h01);
    keys(5'h10, 1'b0);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(st, 8'h00);
    chk(10'h0, 8'h01, {3'h0, pin_drive_o});
    chk(10'h0, 8'h03, {3'h0, pin_drive_oe_o});
    chk(10'h0, 8'h1c, {3'h0, pin_read_valid_o});
    chk(10'h0, 8'h00, {7'h0, wake_o});
    pin_dir_out_i <= 5'h1f;
    pin_port_data_i <= 5'h1f;
    keys(5'h00, 1'b0);
    chk(10'h0, 8'h1f, {3'h0, pin_drive_o});
    wr(en, 8'h1f);
    keys(5'h00, 1'b0);
    chk(10'h0, 8'h00, {3'h0, pin_drive_oe_o});
    chk(10'h0, 8'h00, {3'h0, pin_read_valid_o});
    rd(st, 8'h00);
    keys(5'h02, 1'b0);
    chk(10'h0, 8'h01, {7'h0, wake_o});
    summarize();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    miscompares++;
    summarize();
  end
endmodule : keypad_interrupt_latch_bench
